// >>> logic/rms_map.vh
// register map and field constants of the rate monitor sequencer
`ifndef RMS_MAP_VH
`define RMS_MAP_VH
`define RMS_ADDR_W 8
`define RMS_OFF_CTRL 8'h00
`define RMS_OFF_STATUS 8'h04
`define RMS_OFF_TICK 8'h08
`define RMS_OFF_IP_LO 8'h0c
`define RMS_OFF_IP_HI 8'h10
`define RMS_OFF_IM_LO 8'h14
`define RMS_OFF_IM_HI 8'h18
`define RMS_OFF_INTERVAL 8'h1c
`define RMS_OFF_SLOT_SEL 8'h20
`define RMS_OFF_DATA_ADDR 8'h28
`define RMS_OFF_DATA_WORD 8'h2c
// control field positions
`define RMS_CTRL_RUN 0
`define RMS_CTRL_FIRST_LSB 1
`define RMS_CTRL_LAST_LSB 7
`define RMS_CTRL_REPEAT 13
`define RMS_CTRL_DIV_LSB 14
// status field positions
`define RMS_STAT_RUNNING 0
`define RMS_STAT_IDX_LSB 1
// resources and reset values
`define RMS_SLOTS 64
`define RMS_DATA_DEPTH 2048
`define RMS_CTRL_RST 18'h00000
`define RMS_IDX_RST 6'h00
`define RMS_MASK_RST 64'h0000000000000000
`define RMS_DADDR_RST 12'h000
`endif

// >>> logic/rms_tick_gen.v
// power-of-two prescaler and 32-bit tick counter
`timescale 1ns/1ps
module rms_tick_gen (
  input wire sys_clk, // system clock
  input wire srst, // synchronous reset, active high
  input wire ref_clk_en, // one pulse per reference clock period
  input wire [3:0] div_exp, // prescale exponent
  output reg tick_pulse, // one-cycle pulse per tick
  output reg [31:0] tick_count_q // running tick count
);
  reg [15:0] pre_q;
  wire [15:0] pre_lim;
  // limit is 2^div_exp - 1
  assign pre_lim = (16'h0001 << div_exp) - 16'h0001;
  always @(posedge sys_clk) begin
    if (srst) begin
      pre_q <= 16'h0000;
      tick_pulse <= 1'b0;
      tick_count_q <= 32'h00000000;
    end else begin
      tick_pulse <= 1'b0;
      if (ref_clk_en) begin
        if (pre_q >= pre_lim) begin
          pre_q <= 16'h0000;
          tick_pulse <= 1'b1;
          tick_count_q <= tick_count_q + 32'h00000001;
        end else begin
          pre_q <= pre_q + 16'h0001;
        end
      end
    end
  end
endmodule // rms_tick_gen

// >>> logic/rms_sequencer.v
// control and status core of the rate monitor sequencer
// Overview of operation
// [R01] The sequencer owns 64 command slots and addresses a 2048-entry data set memory.
// [R02] A run bit starts the sequencer when set and requests a stop, honoured at a command boundary, when cleared.
// [R03] The control register holds 6-bit first and last slot indices of the sequence.
// [R04] A repeat bit picks a single pass (0) or an endless loop (1).
// [R05] In single-pass mode the run bit clears itself after the last command completes.
// [R06] A 4-bit exponent sets a power-of-two prescale of the reference clock for a readable 32-bit tick counter.
// [R07] A read-only running flag reads 0 when stopped and 1 when running.
// [R08] After run is cleared the running flag stays 1 until the current command completes.
// [R09] While stopped the status index holds the slot that will execute next on start.
// [R10] When a single pass finishes the status index is reloaded with the first slot index.
// [R11] Software writes the status index inside the first-to-last range before starting.
// [R12] While running the status index shows the slot being executed.
// [R13] Each slot has its own interrupt pending bit, set by its event, and its own mask bit.
// [R14] Each command waits its interval in ticks before executing; an interval of zero runs at once.
// [R15] Execution runs from the status index to the last index and wraps to the first in repeat mode.
`timescale 1ns/1ps
`include "rms_map.vh"
module rms_sequencer (
  input wire sys_clk, // system clock, 25 MHz
  input wire srst, // synchronous reset, active high
  input wire pcie_reference_clock, // reference clock pin, sampled
  input wire [7:0] reg_addr, // register byte address
  input wire [31:0] reg_wdata, // register write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [31:0] reg_rdata, // read data, one cycle after strobe
  output wire cmd_start, // pulse: launch slot on engine
  output wire [5:0] cmd_slot, // slot to execute
  output wire [10:0] data_base, // data set pointer for the engine
  input wire cmd_done, // pulse: engine finished command
  input wire [5:0] done_slot, // slot whose event fired
  input wire slot_event, // pulse: per-slot interrupt event
  output wire irq // level interrupt
);
  // one-hot sequencer states
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_EXEC = 3'b100;

  reg [2:0] state_q;
  reg run_q;
  reg [5:0] first_q;
  reg [5:0] last_q;
  reg repeat_q;
  reg [3:0] div_q;
  reg [5:0] idx_q;
  reg [63:0] pend_q;
  reg [63:0] mask_q;
  reg [31:0] interval_mem [0:63];
  reg [10:0] data_ptr_mem [0:63];
  reg [5:0] sel_q;
  reg [31:0] wait_q;
  reg [1:0] refclk_sync_q;
  reg refclk_prev_q;
  reg [31:0] rd_d;
  wire [31:0] tick_count;
  wire tick_pulse;
  wire ref_clk_en;
  wire ctrl_wr;
  wire [63:0] ip_clr;
  wire [63:0] ev_set;
  wire at_last;

  // bus decode and helpers
  wire [5:0] next_idx;
  wire stop_req;
  wire wr_status;
  wire wr_ip_lo;
  wire wr_ip_hi;
  wire wr_im_lo;
  wire wr_im_hi;
  wire wr_interval;
  wire wr_sel;
  wire wr_daddr;
  wire wr_dword;
  wire rd_dword;
  // next-state values
  reg [2:0] state_d;
  reg [5:0] idx_d;
  reg [31:0] wait_d;
  reg seq_done;
  reg [10:0] data_base_q;
  // data set: two 32-bit words per entry
  reg [11:0] data_addr_q;
  reg [31:0] data_set_mem [0:4095];

  function [63:0] word_mask;
    input [31:0] w;
    input hi;
    begin
      word_mask = hi ? {w, 32'h00000000} : {32'h00000000, w};
    end
  endfunction

  // one strobe hitting one register offset
  function bus_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] off;
    begin
      bus_hit = strobe && (addr == off);
    end
  endfunction

  // successor slot, wrapping at the last index
  function [5:0] slot_after;
    input [5:0] idx;
    input [5:0] first;
    input [5:0] last;
    begin
      slot_after = (idx == last) ? first : idx + 6'h01;
    end
  endfunction

  // reference pin through two flops, then edge detect on second
  always @(posedge sys_clk) begin
    if (srst) begin
      refclk_sync_q <= 2'b00;
      refclk_prev_q <= 1'b0;
    end else begin
      refclk_sync_q <= {refclk_sync_q[0], pcie_reference_clock};
      refclk_prev_q <= refclk_sync_q[1];
    end
  end
  assign ref_clk_en = refclk_sync_q[1] & ~refclk_prev_q;

  // [R06] prescaled tick base
  rms_tick_gen u_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .ref_clk_en(ref_clk_en),
    .div_exp(div_q),
    .tick_pulse(tick_pulse),
    .tick_count_q(tick_count)
  );

  // register decode
  assign ctrl_wr = bus_hit(reg_wr, reg_addr, `RMS_OFF_CTRL);
  assign wr_status = bus_hit(reg_wr, reg_addr, `RMS_OFF_STATUS);
  assign wr_ip_lo = bus_hit(reg_wr, reg_addr, `RMS_OFF_IP_LO);
  assign wr_ip_hi = bus_hit(reg_wr, reg_addr, `RMS_OFF_IP_HI);
  assign wr_im_lo = bus_hit(reg_wr, reg_addr, `RMS_OFF_IM_LO);
  assign wr_im_hi = bus_hit(reg_wr, reg_addr, `RMS_OFF_IM_HI);
  assign wr_interval = bus_hit(reg_wr, reg_addr, `RMS_OFF_INTERVAL);
  assign wr_sel = bus_hit(reg_wr, reg_addr, `RMS_OFF_SLOT_SEL);
  assign wr_daddr = bus_hit(reg_wr, reg_addr, `RMS_OFF_DATA_ADDR);
  assign wr_dword = bus_hit(reg_wr, reg_addr, `RMS_OFF_DATA_WORD);
  assign rd_dword = bus_hit(reg_rd, reg_addr, `RMS_OFF_DATA_WORD);

  // sequencing helpers
  assign at_last = (idx_q == last_q);
  assign next_idx = slot_after(idx_q, first_q, last_q);
  // [R02] run cleared by software, possibly in this very cycle
  assign stop_req = !run_q || (ctrl_wr && !reg_wdata[`RMS_CTRL_RUN]);

  // [R01] per-slot tables, data pointer inside 2048 entries
  always @(posedge sys_clk) begin
    if (wr_interval) begin
      interval_mem[sel_q] <= reg_wdata;
    end
    if (wr_sel) begin
      data_ptr_mem[reg_wdata[5:0]] <= reg_wdata[26:16];
    end
  end

  // [R01] data set memory, software walks it by auto-increment
  always @(posedge sys_clk) begin
    if (srst) begin
      data_addr_q <= `RMS_DADDR_RST;
    end else if (wr_daddr) begin
      data_addr_q <= reg_wdata[11:0];
    end else if (wr_dword || rd_dword) begin
      data_addr_q <= data_addr_q + 12'h001;
    end
  end

  // word store
  always @(posedge sys_clk) begin
    if (wr_dword) begin
      data_set_mem[data_addr_q] <= reg_wdata;
    end
  end

  // sequencer next state
  always @* begin
    state_d = state_q;
    idx_d = idx_q;
    wait_d = wait_q;
    seq_done = 1'b0;

    // [R09] software loads next index only while stopped
    if (wr_status && state_q == ST_IDLE) begin
      idx_d = reg_wdata[`RMS_STAT_IDX_LSB +: 6];
    end
    case (state_q)
      ST_IDLE: begin
        if (run_q) begin
          wait_d = interval_mem[idx_q];
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // [R14] interval in ticks, zero runs at once
        if (wait_q == 32'h00000000) begin
          state_d = ST_EXEC;
        end else if (tick_pulse) begin
          wait_d = wait_q - 32'h00000001;
        end
      end
      ST_EXEC: begin
        // [R02] [R08] stop only at command boundary
        if (cmd_done) begin
          if (at_last && !repeat_q) begin
            // [R10] single pass ends at first slot
            seq_done = 1'b1;
            idx_d = first_q;
            state_d = ST_IDLE;
          end else begin
            // [R15] advance, wrap to first
            idx_d = next_idx;
            if (stop_req) begin
              state_d = ST_IDLE;
            end else begin
              wait_d = interval_mem[next_idx];
              state_d = ST_WAIT;
            end
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // control register and sequencer registers
  always @(posedge sys_clk) begin
    if (srst) begin
      run_q <= 1'b0;
      first_q <= `RMS_IDX_RST;
      last_q <= `RMS_IDX_RST;
      repeat_q <= 1'b0;
      div_q <= 4'h0;
      idx_q <= `RMS_IDX_RST;
      state_q <= ST_IDLE;
      wait_q <= 32'h00000000;
      sel_q <= 6'h00;
    end else begin
      if (wr_sel) begin
        sel_q <= reg_wdata[5:0];
      end
      if (ctrl_wr) begin
        // [R02] run bit start or stop request
        run_q <= reg_wdata[`RMS_CTRL_RUN];
        // [R03] first and last slot indices
        first_q <= reg_wdata[`RMS_CTRL_FIRST_LSB +: 6];
        last_q <= reg_wdata[`RMS_CTRL_LAST_LSB +: 6];
        // [R04] repeat selection
        repeat_q <= reg_wdata[`RMS_CTRL_REPEAT];
        div_q <= reg_wdata[`RMS_CTRL_DIV_LSB +: 4];
      end
      // [R05] run clears itself after a single pass
      if (seq_done) begin
        run_q <= 1'b0;
      end
      state_q <= state_d;
      idx_q <= idx_d;
      wait_q <= wait_d;
    end
  end

  // launch pulse when interval expires; engine answers with cmd_done
  assign cmd_start = (state_q == ST_WAIT) && (wait_q == 32'h00000000);
  // [R12] running slot goes to engine
  assign cmd_slot = idx_q;

  // [R01] data pointer of the slot in hand, registered
  always @(posedge sys_clk) begin
    if (srst) begin
      data_base_q <= 11'h000;
    end else if (wr_sel && reg_wdata[5:0] == idx_d) begin
      data_base_q <= reg_wdata[26:16];
    end else begin
      data_base_q <= data_ptr_mem[idx_d];
    end
  end
  assign data_base = data_base_q;

  // [R13] per-slot pending and mask, set wins over clear
  assign ev_set = slot_event ? (64'h0000000000000001 << done_slot) : 64'h0000000000000000;
  // write one to clear
  assign ip_clr = wr_ip_lo ? word_mask(reg_wdata, 1'b0) :
                  wr_ip_hi ? word_mask(reg_wdata, 1'b1) :
                  64'h0000000000000000;
  always @(posedge sys_clk) begin
    if (srst) begin
      pend_q <= 64'h0000000000000000;
      mask_q <= `RMS_MASK_RST;
    end else begin
      pend_q <= (pend_q & ~ip_clr) | ev_set;
      if (wr_im_lo) begin
        mask_q[31:0] <= reg_wdata;
      end
      if (wr_im_hi) begin
        mask_q[63:32] <= reg_wdata;
      end
    end
  end
  // mask bit 1 enables the pending bit
  assign irq = |(pend_q & mask_q);

  // read mux
  always @* begin
    rd_d = 32'h00000000;
    case (reg_addr)
      `RMS_OFF_CTRL: rd_d = {14'h0000, div_q, repeat_q, last_q, first_q, run_q};
      // [R07] [R08] running flag while a command is in hand
      `RMS_OFF_STATUS: rd_d = {25'h0000000, idx_q, (state_q != ST_IDLE)};
      `RMS_OFF_TICK: rd_d = tick_count;
      `RMS_OFF_IP_LO: rd_d = pend_q[31:0];
      `RMS_OFF_IP_HI: rd_d = pend_q[63:32];
      `RMS_OFF_IM_LO: rd_d = mask_q[31:0];
      `RMS_OFF_IM_HI: rd_d = mask_q[63:32];
      `RMS_OFF_INTERVAL: rd_d = interval_mem[sel_q];
      `RMS_OFF_SLOT_SEL: rd_d = {5'h00, data_ptr_mem[sel_q], 10'h000, sel_q};
      `RMS_OFF_DATA_ADDR: rd_d = {20'h00000, data_addr_q};
      `RMS_OFF_DATA_WORD: rd_d = data_set_mem[data_addr_q];
      default: rd_d = 32'h00000000;
    endcase
  end

  // read data stands one cycle, zero otherwise
  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule // rms_sequencer

// >>> dv/rms_sequencer_props.sv
// port-level assertions of the rate monitor sequencer
`timescale 1ns/1ps
`include "rms_map.vh"
module rms_sequencer_props (
  input wire sys_clk, // clock
  input wire srst, // sync reset
  input wire [7:0] reg_addr, // address
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  input wire [31:0] reg_rdata, // read data
  input wire cmd_start, // launch pulse
  input wire [5:0] cmd_slot, // current slot
  input wire cmd_done, // engine done
  input wire slot_event, // slot event
  input wire irq // interrupt
);
  reg exec_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // command in flight
  always @(posedge sys_clk) begin
    if (srst || cmd_done)
      exec_q <= 1'b0;
    else if (cmd_start)
      exec_q <= 1'b1;
  end
  sequence status_rd_s;
    $past(reg_rd) && ($past(reg_addr) == `RMS_OFF_STATUS);
  endsequence
  sequence busy_rd_s;
    status_rd_s ##0 ($past(exec_q) || $past(cmd_start));
  endsequence
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  unmapped_rd_a: assert property ($past(reg_rd) && ($past(reg_addr) > 8'h2f) |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  index_read_a: assert property (status_rd_s |-> reg_rdata[6:1] == $past(cmd_slot))
    else $error("status index differs from slot");
  running_read_a: assert property (busy_rd_s |-> reg_rdata[0])
    else $error("running flag low during command");
  start_once_a: assert property (cmd_start |=> !cmd_start)
    else $error("launch longer than one cycle");
  no_overlap_a: assert property (cmd_start |-> !exec_q)
    else $error("launch before previous command done");
  slot_hold_a: assert property ($changed(cmd_slot) |-> $past(cmd_done) || $past(reg_wr))
    else $error("slot changed without cause");
  irq_rise_a: assert property ($rose(irq) |-> $past(slot_event) || $past(reg_wr))
    else $error("interrupt rose without cause");
endmodule // rms_sequencer_props
bind rms_sequencer rms_sequencer_props u_props (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_start(cmd_start), .cmd_slot(cmd_slot),
  .cmd_done(cmd_done), .slot_event(slot_event), .irq(irq));

// >>> dv/counter_rate_monitor_sequencer_tb_top.sv
// self-checking bench of the rate monitor sequencer
`timescale 1ns/1ps
module counter_rate_monitor_sequencer_tb_top;
  reg sys_clk = 0, srst = 1, refc = 0, wr = 0, rd = 0, done = 0, ev = 0;
  reg [7:0] addr = 0;
  reg [31:0] wdata = 0;
  reg [5:0] dslot = 0;
  reg [71:0] rows [0:9];
  wire [31:0] rdata;
  wire start, irq;
  wire [5:0] slot;
  wire [10:0] base;
  integer miscompares = 0, check_count = 0, cyc = 0, i, n;
  rms_sequencer dut (.sys_clk(sys_clk), .srst(srst), .pcie_reference_clock(refc), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .cmd_start(start), .cmd_slot(slot),
    .data_base(base), .cmd_done(done), .done_slot(dslot), .slot_event(ev), .irq(irq));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task check(input [31:0] seen, input [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wrt(input [7:0] a, input [31:0] d);
    addr <= a; wdata <= d; wr <= 1;
    @(posedge sys_clk); wr <= 0;
    @(posedge sys_clk);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    addr <= a; rd <= 1;
    @(posedge sys_clk); rd <= 0;
    #1 check(rdata, e);
    @(posedge sys_clk);
  endtask
  task bit_is(input v, input e);
    #1 check({31'h0, v}, {31'h0, e});
    @(posedge sys_clk);
  endtask
  task run_cmd(input [5:0] s, input [10:0] b, input stop);
    n = 0;
    #1;
    while (start !== 1'b1 && n < 100) begin
      @(posedge sys_clk); #1; n = n + 1;
    end
    check({31'h0, n < 100}, 32'h1);
    check({26'h0, slot}, {26'h0, s});
    check({21'h0, base}, {21'h0, b});
    @(posedge sys_clk);
    if (stop) begin
      wrt(8'h00, 32'h2184);
      rdc(8'h04, {25'h0, s, 1'b1});
    end
    done <= 1;
    @(posedge sys_clk); done <= 0;
  endtask
  task ref_edges(input integer k);
    repeat (k) begin
      refc <= 1; repeat (3) @(posedge sys_clk);
      refc <= 0; repeat (3) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      end_of_test;
    end
  end
  initial begin
    rows[0] = {8'h00, 32'h16184, 32'h16184}; rows[1] = {8'h00, 32'h184, 32'h184};
    rows[2] = {8'h04, 32'h5, 32'h4}; rows[3] = {8'h14, 32'h20, 32'h20};
    rows[4] = {8'h18, 32'h1, 32'h1}; rows[5] = {8'h24, 32'hff, 32'h0};
    rows[6] = {8'h20, 32'h07ff0002, 32'h07ff0002}; rows[7] = {8'h1c, 32'h0, 32'h0};
    rows[8] = {8'h20, 32'h01230003, 32'h01230003}; rows[9] = {8'h1c, 32'h0, 32'h0};
    repeat (5) @(posedge sys_clk);
    srst <= 0;
    @(posedge sys_clk);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    for (i = 0; i < 10; i = i + 1) begin
      wrt(rows[i][71:64], rows[i][63:32]);
      rdc(rows[i][71:64], rows[i][31:0]);
    end
    // single pass then self stop
    wrt(8'h00, 32'h185);
    run_cmd(6'h02, 11'h7ff, 1'b0);
    run_cmd(6'h03, 11'h123, 1'b0);
    rdc(8'h04, 32'h4);
    rdc(8'h00, 32'h184);
    // looping run stopped at a boundary
    wrt(8'h04, 32'h6);
    wrt(8'h00, 32'h2185);
    run_cmd(6'h03, 11'h123, 1'b1);
    rdc(8'h04, 32'h4);
    bit_is(start, 1'b0);
    dslot <= 6'h05; ev <= 1;
    @(posedge sys_clk); ev <= 0;
    @(posedge sys_clk);
    bit_is(irq, 1'b1);
    rdc(8'h0c, 32'h20);
    wrt(8'h14, 32'h0);
    bit_is(irq, 1'b0);
    wrt(8'h14, 32'h20);
    bit_is(irq, 1'b1);
    wrt(8'h0c, 32'h20);
    bit_is(irq, 1'b0);
    ref_edges(4);
    rdc(8'h08, 32'h4);
    wrt(8'h00, 32'h4184);
    ref_edges(4);
    rdc(8'h08, 32'h6);
    // nonzero interval waits for ticks
    wrt(8'h20, 32'h07ff0002);
    wrt(8'h1c, 32'h2);
    wrt(8'h00, 32'h105);
    ref_edges(1);
    bit_is(start, 1'b0);
    refc <= 1;
    run_cmd(6'h02, 11'h7ff, 1'b0);
    refc <= 0;
    rdc(8'h08, 32'h8);
    rdc(8'h00, 32'h104);
    // data set memory walk
    wrt(8'h28, 32'h7fe);
    wrt(8'h2c, 32'hcafe0001);
    wrt(8'h2c, 32'h12345678);
    wrt(8'h28, 32'h7fe);
    rdc(8'h2c, 32'hcafe0001);
    rdc(8'h2c, 32'h12345678);
    rdc(8'h28, 32'h800);
    end_of_test;
  end
endmodule // counter_rate_monitor_sequencer_tb_top
